//--- inc/pwsc_pkg.sv
/*
  Package for the power, sleep and misc configuration register bank:
  register offsets, field positions, reset values and the packed carriers.
  Assumes it is compiled before every file of the block.
*/
package pwsc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (page zero, byte addresses on the control port)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_SOFTWARE_RESET = 8'h01;
  localparam logic [7:0] OFS_REF_SLEEP = 8'h02;
  localparam logic [7:0] OFS_SUPPLY_STATUS = 8'h03;
  localparam logic [7:0] OFS_CLKERR_BCAST = 8'h04;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_REF_SLEEP = 8'h00;
  localparam logic [7:0] RST_SUPPLY_STATUS = 8'h00;
  localparam logic [7:0] RST_CLKERR_BCAST = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int BIT_SOFTWARE_RESET = 0;
  localparam int BIT_QCHG_HI = 5;
  localparam int BIT_QCHG_LO = 4;
  localparam int BIT_SLEEP_EXIT_REF = 3;
  localparam int BIT_ANALOG_MODE = 2;
  localparam int BIT_IO_MODE = 1;
  localparam int BIT_AWAKE = 0;
  localparam int BIT_ANALOG_FLAG = 7;
  localparam int BIT_IO_FLAG = 6;
  localparam int BIT_UV_FLAG = 1;
  localparam int BIT_UV_WAKE = 0;
  localparam int BIT_IGNORE_CLKERR = 6;
  localparam int BIT_BCAST_EN = 1;

  // Quick-charge duration codes (about 3.5, 10, 50 and 100 ms)
  typedef enum logic [1:0] {
    PWSC_QCHG_3P5MS = 2'b00,
    PWSC_QCHG_10MS = 2'b01,
    PWSC_QCHG_50MS = 2'b10,
    PWSC_QCHG_100MS = 2'b11
  } pwsc_qchg_t;

  // Supply and fault status from the analog side (asynchronous levels)
  typedef struct packed {
    logic analogSupplyHigh;
    logic ioSupplyHigh;
    logic undervoltageShutdown;
    logic clockError;
  } pwsc_status_t;

  // Controls to the analog side
  typedef struct packed {
    pwsc_qchg_t quickChargeTime;
    logic analogSupplyMode;
    logic ioSupplyMode;
    logic awake;
    logic digitalRegulatorEnable;
    logic referenceEnable;
    logic clockErrorShutdown;
    logic broadcastAddressEnable;
  } pwsc_ctrl_t;

endpackage : pwsc_pkg

//--- rtl/pwsc_sync.sv
/*
  Two-flop synchroniser, one stage pair per bit.
  Assumes the inputs are levels slower than the clock.
*/
`timescale 1ns/100ps
`default_nettype none

module pwsc_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Levels
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  // ----------------------------------------------------------------------
  // Per-bit stages
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic stage1;
      logic stage2;
      // First flop feeds only the second
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
        end else begin
          stage1 <= asyncIn[i];
          stage2 <= stage1;
        end
      end
      // Each bit has its own driver
      assign syncOut[i] = stage2;
    end
  endgenerate

endmodule : pwsc_sync

`default_nettype wire

//--- rtl/pwsc_regs.sv
/*
  Power, sleep and misc configuration register bank of page zero.
  Assumes the control interface has decoded a page-zero access into
  one-cycle read and write strobes on clk_sys; status levels are async.
*/
`timescale 1ns/100ps
`default_nettype none

// How it works
// [R1] Bits 5-4 of 0x2 choose the reference quick-charge duration.
// [R2] Bit 3 of 0x2: wake powers digital regulator, or also reference.
// [R3] Bit 2 of 0x2 selects internal analog regulator or direct supply.
// [R4] Bit 1 of 0x2 selects all-voltage or low-voltage-only I/O mode.
// [R5] Bit 0 of 0x2 zero keeps sleep, one wakes; starts asleep.
// [R6] Bit 7 of 0x3 shows analog supply high and forces mode zero.
// [R7] Bit 6 of 0x3 shows I/O supply high and forces mode zero.
// [R8] Bit 1 of 0x3 reads one after an undervoltage shutdown.
// [R9] Bit 0 of 0x3 chooses staying asleep or waking after that shutdown.
// [R10] Bit 6 of 0x4 zero shuts down on clock error, one ignores it.
// [R11] Bit 1 of 0x4 enables broadcast addressing with low bits zero.
// [R12] Host writes only reset values into reserved bits.
// [R13] Writing one to the software reset bit restores all defaults except the supply flags and a shutdown flag set in that same cycle.
// [R14] Host writes to 0x3 never change its read-only status bits.
module pwsc_regs (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register access from the control interface
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic regRdValid,
  // Analog side
  input wire pwsc_pkg::pwsc_status_t statusIn,
  output var pwsc_pkg::pwsc_ctrl_t ctrlOut
);

  // ----------------------------------------------------------------------
  // Storage and synchronised status
  // ----------------------------------------------------------------------
  logic [7:0] refSleepCfg;
  logic [7:0] clkErrBcastCfg;
  logic undervoltageWakeSelect;
  logic undervoltageShutdownFlag;
  logic analogSupplyOverrideFlag;
  logic ioSupplyOverrideFlag;
  pwsc_pkg::pwsc_status_t statusSync;
  logic softwareResetHit;
  logic wrRefSleep;
  logic wrSupply;
  logic wrClkErr;
  logic [7:0] next_rdata;

  // Status levels cross into clk_sys
  pwsc_sync #(
    .WIDTH($bits(pwsc_pkg::pwsc_status_t))
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .asyncIn(statusIn),
    .syncOut(statusSync)
  );

  // Write decode
  assign softwareResetHit = regWrite &&
    regAddr == pwsc_pkg::OFS_SOFTWARE_RESET &&
    regWdata[pwsc_pkg::BIT_SOFTWARE_RESET]; // see [R13]
  assign wrRefSleep = regWrite && regAddr == pwsc_pkg::OFS_REF_SLEEP;
  assign wrSupply = regWrite && regAddr == pwsc_pkg::OFS_SUPPLY_STATUS;
  assign wrClkErr = regWrite && regAddr == pwsc_pkg::OFS_CLKERR_BCAST;

  // ----------------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------------
  // Reference and sleep configuration; reserved bits stored as written
  always_ff @(posedge clk_sys) begin
    if (rst || softwareResetHit) begin // see [R13]
      refSleepCfg <= pwsc_pkg::RST_REF_SLEEP; // see [R5]
    end else if (wrRefSleep) begin
      refSleepCfg <= regWdata; // see [R12]
    end
  end

  // Clock-error action and broadcast configuration
  always_ff @(posedge clk_sys) begin
    if (rst || softwareResetHit) begin // see [R13]
      clkErrBcastCfg <= pwsc_pkg::RST_CLKERR_BCAST;
    end else if (wrClkErr) begin
      clkErrBcastCfg <= regWdata;
    end
  end

  // Only bit 0 of the supply status register is writable
  always_ff @(posedge clk_sys) begin
    if (rst || softwareResetHit) begin // see [R13]
      undervoltageWakeSelect <= pwsc_pkg::RST_SUPPLY_STATUS[0];
    end else if (wrSupply) begin
      undervoltageWakeSelect <= regWdata[pwsc_pkg::BIT_UV_WAKE]; // see [R14]
    end
  end

  // ----------------------------------------------------------------------
  // Hardware status flags
  // ----------------------------------------------------------------------
  // Supply flags follow the detectors; host writes have no path here
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      analogSupplyOverrideFlag <= 1'b0;
      ioSupplyOverrideFlag <= 1'b0;
    end else begin
      analogSupplyOverrideFlag <= statusSync.analogSupplyHigh; // see [R6]
      ioSupplyOverrideFlag <= statusSync.ioSupplyHigh; // see [R7] [R14]
    end
  end

  // Sticky shutdown flag; a new event wins over the software reset clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      undervoltageShutdownFlag <= 1'b0;
    end else if (statusSync.undervoltageShutdown) begin
      undervoltageShutdownFlag <= 1'b1; // see [R8]
    end else if (softwareResetHit) begin
      undervoltageShutdownFlag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Unmapped and reset-register reads return zero
  always_comb begin
    next_rdata = 8'h00;
    case (regAddr)
      pwsc_pkg::OFS_REF_SLEEP: begin
        next_rdata = refSleepCfg;
      end
      pwsc_pkg::OFS_SUPPLY_STATUS: begin
        next_rdata[pwsc_pkg::BIT_ANALOG_FLAG] = analogSupplyOverrideFlag;
        next_rdata[pwsc_pkg::BIT_IO_FLAG] = ioSupplyOverrideFlag;
        next_rdata[pwsc_pkg::BIT_UV_FLAG] = undervoltageShutdownFlag;
        next_rdata[pwsc_pkg::BIT_UV_WAKE] = undervoltageWakeSelect;
      end
      pwsc_pkg::OFS_CLKERR_BCAST: begin
        next_rdata = clkErrBcastCfg;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      regRdata <= 8'h00;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRead;
      if (regRead) begin
        regRdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Controls to the analog side
  // ----------------------------------------------------------------------
  logic next_awake;
  always_comb begin
    // After a shutdown the wake select decides, else the awake bit
    if (undervoltageShutdownFlag) begin
      next_awake = undervoltageWakeSelect; // see [R9]
    end else begin
      next_awake = refSleepCfg[pwsc_pkg::BIT_AWAKE]; // see [R5]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrlOut <= '0;
    end else begin
      ctrlOut.quickChargeTime <= pwsc_pkg::pwsc_qchg_t'(
        refSleepCfg[pwsc_pkg::BIT_QCHG_HI:pwsc_pkg::BIT_QCHG_LO]); // see [R1]
      ctrlOut.analogSupplyMode <= refSleepCfg[pwsc_pkg::BIT_ANALOG_MODE] &&
        !analogSupplyOverrideFlag; // see [R3] [R6]
      ctrlOut.ioSupplyMode <= refSleepCfg[pwsc_pkg::BIT_IO_MODE] &&
        !ioSupplyOverrideFlag; // see [R4] [R7]
      ctrlOut.awake <= next_awake;
      ctrlOut.digitalRegulatorEnable <= next_awake; // see [R2]
      ctrlOut.referenceEnable <= next_awake &&
        refSleepCfg[pwsc_pkg::BIT_SLEEP_EXIT_REF]; // see [R2]
      ctrlOut.clockErrorShutdown <= statusSync.clockError &&
        !clkErrBcastCfg[pwsc_pkg::BIT_IGNORE_CLKERR]; // see [R10]
      ctrlOut.broadcastAddressEnable <=
        clkErrBcastCfg[pwsc_pkg::BIT_BCAST_EN]; // see [R11]
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  property p_qchg;
    wrRefSleep |-> ##2 ctrlOut.quickChargeTime == $past(regWdata[5:4], 2);
  endproperty
  a_qchg: assert property (p_qchg) // see [R1]
    else $error("quick-charge output does not follow write");

  property p_ref_en;
    ctrlOut.referenceEnable |-> ctrlOut.digitalRegulatorEnable &&
      $past(refSleepCfg[pwsc_pkg::BIT_SLEEP_EXIT_REF]);
  endproperty
  a_ref_en: assert property (p_ref_en) // see [R2]
    else $error("reference enabled without digital regulator");

  property p_analog_force;
    statusSync.analogSupplyHigh |-> ##2 !ctrlOut.analogSupplyMode;
  endproperty
  a_analog_force: assert property (p_analog_force) // see [R6]
    else $error("analog mode not forced to zero");

  property p_io_force;
    statusSync.ioSupplyHigh |-> ##2 !ctrlOut.ioSupplyMode;
  endproperty
  a_io_force: assert property (p_io_force) // see [R7]
    else $error("io mode not forced to zero");

  property p_io_mode;
    wrRefSleep && !statusSync.ioSupplyHigh && !ioSupplyOverrideFlag
      ##1 !ioSupplyOverrideFlag |=> ctrlOut.ioSupplyMode == $past(regWdata[1], 2);
  endproperty
  a_io_mode: assert property (p_io_mode) // see [R4]
    else $error("io mode does not follow configuration");

  property p_uv_flag;
    statusSync.undervoltageShutdown ##1 !softwareResetHit |->
      undervoltageShutdownFlag ##1 undervoltageShutdownFlag;
  endproperty
  a_uv_flag: assert property (p_uv_flag) // see [R8]
    else $error("shutdown flag not set");

  property p_uv_wake;
    undervoltageShutdownFlag |=> ctrlOut.awake == $past(undervoltageWakeSelect);
  endproperty
  a_uv_wake: assert property (p_uv_wake) // see [R9]
    else $error("wake after shutdown ignores select");

  property p_clkerr;
    statusSync.clockError && clkErrBcastCfg[6] |=> !ctrlOut.clockErrorShutdown;
  endproperty
  a_clkerr: assert property (p_clkerr) // see [R10]
    else $error("clock error not ignored");

  property p_clkerr_shdn;
    statusSync.clockError && !clkErrBcastCfg[pwsc_pkg::BIT_IGNORE_CLKERR] |=>
      ctrlOut.clockErrorShutdown;
  endproperty
  a_clkerr_shdn: assert property (p_clkerr_shdn) // see [R10]
    else $error("clock error did not request shutdown");

  property p_bcast;
    wrClkErr |-> ##2 ctrlOut.broadcastAddressEnable == $past(regWdata[1], 2);
  endproperty
  a_bcast: assert property (p_bcast) // see [R11]
    else $error("broadcast enable does not follow write");

  property p_swreset;
    softwareResetHit |=> refSleepCfg == 8'h00 && clkErrBcastCfg == 8'h00
      && !undervoltageWakeSelect ##1 !ctrlOut.referenceEnable;
  endproperty
  a_swreset: assert property (p_swreset) // see [R13]
    else $error("software reset did not restore defaults");

  property p_ro_status;
    wrSupply && !statusSync.undervoltageShutdown |=>
      undervoltageShutdownFlag == $past(undervoltageShutdownFlag);
  endproperty
  a_ro_status: assert property (p_ro_status) // see [R14]
    else $error("host write changed shutdown flag");

endmodule : pwsc_regs

`default_nettype wire

//--- tb/pwsc_host_model.sv
/*
  Host controller model: issues one-cycle register strobes on the falling
  edge. Assumes the bench calls its tasks and that reset has been released.
*/
`timescale 1ns/100ps
`default_nettype none

module pwsc_host_model (
  // Clock
  input wire logic clk_sys,
  // Register strobes
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata
);
  // --------------------------------------------------------------------
  // Idle state at time zero
  // --------------------------------------------------------------------
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
  end

  // Defined bits per offset; reserved bits carry zero, unmapped offsets pass all bits
  function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
      8'h01: return 8'h01;
      8'h02: return 8'h3f;
      8'h03: return 8'hc3;
      8'h04: return 8'h42;
      default: return 8'hff;
    endcase
  endfunction : wmask

  // One write strobe, then the bus is scrambled so stale data never helps
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    regAddr = a;
    regWdata = d & wmask(a);
    regWrite = 1'b1;
    @(negedge clk_sys);
    regWrite = 1'b0;
    regAddr = ~regAddr;
    regWdata = ~regWdata;
  endtask : write_reg

  // One read strobe
  task automatic read_reg(input logic [7:0] a);
    @(negedge clk_sys);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clk_sys);
    regRead = 1'b0;
    regAddr = ~regAddr;
  endtask : read_reg
endmodule : pwsc_host_model
`default_nettype wire

//--- tb/test_pwsc_regs.sv
/*
  Self-checking bench of the register bank: reads are scored from a queue.
  Assumes the package and design files are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module test_pwsc_regs;
  logic clk_sys, rst, regWrite, regRead, regRdValid;
  logic [7:0] regAddr, regWdata, regRdata, r2, r4;
  logic wake, uv;
  logic [31:0] rnd = 32'h41;
  pwsc_pkg::pwsc_status_t st;
  pwsc_pkg::pwsc_ctrl_t ctrlOut;
  logic [15:0] expQ[$];
  int nMismatch = 0;
  int samplesChecked = 0;
  int cycles = 0;

  pwsc_regs pwsc_regs_inst (.clk_sys(clk_sys), .rst(rst),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .regRdValid(regRdValid),
    .statusIn(st), .ctrlOut(ctrlOut));
  pwsc_host_model pwsc_host_model_inst (.clk_sys(clk_sys),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata));

  // --------------------------------------------------------------------
  // Clock, timeout and helpers
  // --------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Cuts a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      nMismatch++;
      complete_run();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs

  // Expected controls from the mirrored register state
  function automatic pwsc_pkg::pwsc_ctrl_t ctrl_exp();
    pwsc_pkg::pwsc_ctrl_t c;
    logic aw;
    aw = uv ? wake : r2[0];
    c.quickChargeTime = pwsc_pkg::pwsc_qchg_t'(r2[5:4]);
    c.analogSupplyMode = r2[2] & ~st.analogSupplyHigh;
    c.ioSupplyMode = r2[1] & ~st.ioSupplyHigh;
    c.awake = aw;
    c.digitalRegulatorEnable = aw;
    c.referenceEnable = aw & r2[3];
    c.clockErrorShutdown = st.clockError & ~r4[6];
    c.broadcastAddressEnable = r4[1];
    return c;
  endfunction : ctrl_exp

  function automatic logic [7:0] sts_exp();
    return {st.analogSupplyHigh, st.ioSupplyHigh, 4'h0, uv, wake};
  endfunction : sts_exp

  task automatic check_byte(input logic [7:0] a, input logic [7:0] e,
                            input logic [7:0] g);
    samplesChecked++;
    if (g !== e) begin
      nMismatch++;
      $display("wrong value read of %h expected %h seen %h", a, e, g);
    end
  endtask : check_byte

  task automatic check_ctrl();
    samplesChecked++;
    if (ctrlOut !== ctrl_exp()) begin
      nMismatch++;
      $display("wrong value ctrlOut expected %h seen %h", ctrl_exp(),
               ctrlOut);
    end
  endtask : check_ctrl

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back({a, e});
    pwsc_host_model_inst.read_reg(a);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    pwsc_host_model_inst.write_reg(a, d);
  endtask : wr

  // Lets synchronisers and output registers settle, then checks controls
  task automatic settle();
    repeat (5) @(negedge clk_sys);
    check_ctrl();
  endtask : settle

  task automatic complete_run();
    $display("mismatches %0d, comparisons %0d", nMismatch, samplesChecked);
    if (nMismatch == 0 && samplesChecked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  // Read result scoreboard
  always @(negedge clk_sys) begin
    if (regRdValid === 1'b1) begin
      if (expQ.size() == 0) begin
        nMismatch++;
        $display("wrong value regRdValid expected 0 seen 1");
      end else begin
        check_byte(expQ[0][15:8], expQ[0][7:0], regRdata);
        void'(expQ.pop_front());
      end
    end
  end

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    st = '0;
    {r2, r4, wake, uv} = '0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    settle();
    rd(8'h02, 8'h00);
    rd(8'h03, 8'h00);
    rd(8'h04, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rnd = xs(rnd);
      r2 = {2'b00, 2'(i), rnd[3:0]};
      wr(8'h02, r2);
      settle();
      rd(8'h02, r2);
    end
    for (int i = 0; i < 3; i++) begin
      rnd = xs(rnd);
      r4 = rnd[7:0] & 8'h42;
      wr(8'h04, r4);
      rd(8'h04, r4);
      settle();
    end
    r4 = 8'h00;
    wr(8'h04, r4);
    st.clockError = 1'b1;
    settle();
    r4 = 8'h40;
    wr(8'h04, r4);
    settle();
    st.clockError = 1'b0;
    wake = 1'b1;
    wr(8'h03, 8'hc3);
    rd(8'h03, 8'h01);
    r2 = 8'h07;
    wr(8'h02, r2);
    st.analogSupplyHigh = 1'b1;
    st.ioSupplyHigh = 1'b1;
    settle();
    rd(8'h03, sts_exp());
    // Awake with the reference bit set powers both
    r2 = 8'h09;
    wr(8'h02, r2);
    settle();
    r2 = 8'h08;
    wr(8'h02, r2);
    settle();
    st.undervoltageShutdown = 1'b1;
    repeat (4) @(negedge clk_sys);
    st.undervoltageShutdown = 1'b0;
    uv = 1'b1;
    settle();
    rd(8'h03, sts_exp());
    // After the shutdown the wake select overrides the awake bit
    wake = 1'b0;
    wr(8'h03, 8'h00);
    r2 = 8'h09;
    wr(8'h02, r2);
    settle();
    rd(8'h03, sts_exp());
    wr(8'h04, 8'h42);
    wr(8'h01, 8'h01);
    {r2, r4, wake, uv} = '0;
    settle();
    rd(8'h02, 8'h00);
    rd(8'h03, sts_exp());
    rd(8'h04, 8'h00);
    rd(8'h01, 8'h00);
    rd(8'h10, 8'h00);
    st = '0;
    settle();
    rd(8'h03, 8'h00);
    repeat (3) @(negedge clk_sys);
    // Every read issued must have been answered
    samplesChecked++;
    if (expQ.size() != 0) begin
      nMismatch++;
      $display("wrong value pending reads expected 0 seen %0d", expQ.size());
    end
    complete_run();
  end
endmodule : test_pwsc_regs
`default_nettype wire
